// >>> design/encoder_position_serial_out.sv
/*
  Serial position output of an absolute encoder: synchronous serial and
  BiSS-C frames clocked by an external master, plus a service mode switch.
  Assumes the link clock pin is asynchronous to clk and idles high.
*/
`timescale 1ns/10ps
`default_nettype none
module encoder_position_serial_out
  import enc_out_pkg::*;
#(
  parameter int REFRESH_HZ = REFRESH_HZ_DEF
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Link pins
  input  wire logic             linkClkIn,
  output logic                  dataOut,
  // Configuration
  input  wire logic             fmtBiss,
  input  wire logic [RES_W-1:0] resBits,
  input  wire logic             bitFitted,
  input  wire logic             bitFault,
  input  wire logic             serviceReq,
  // Service link
  output logic                  serviceRx,
  input  wire logic             serviceTx,
  output logic                  serviceActive,
  // Position source
  output logic                  sampleReq,
  input  wire logic [POS_W-1:0] posData,
  input  wire logic             posValid,
  output logic                  posReady
);

  localparam int REFRESH_CYC = CLK_HZ / REFRESH_HZ;
  localparam logic [REF_W-1:0] REF_RELOAD = REF_W'(REFRESH_CYC - 1);

  // Six-bit CRC over a left-aligned vector of len bits
  function automatic logic [CRC_W-1:0] crc6(input logic [CRCIN_W-1:0] vec,
                                            input logic [LEN_W-1:0]   len);
    logic [CRC_W-1:0] crc;
    logic             fb;
    crc = '0;
    for (int i = 0; i < CRCIN_W; i++) begin
      if (LEN_W'(i) < len) begin
        fb  = vec[CRCIN_W-1-i] ^ crc[CRC_W-1];
        crc = {crc[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
      end
    end
    return crc;
  endfunction

  // Link clock synchroniser and edge history
  logic             clkS1_ff;
  logic             clkS2_ff;
  logic             clkS3_ff;
  wire              riseEdge;
  wire              fallEdge;
  wire              anyEdge;

  // Frame engine
  state_t           state_ff;
  logic [FRM_W-1:0] shift_ff;
  logic [LEN_W-1:0] bitsLeft_ff;
  logic [TO_W-1:0]  toCnt_ff;
  logic             dataOut_ff;

  // Position sample path
  logic [REF_W-1:0] refCnt_ff;
  logic             sampleReq_ff;
  logic [POS_W-1:0] sample_ff;
  wire              fifoValid;
  wire [POS_W-1:0]  fifoData;
  wire              fifoReady;

  // Frame build
  wire [RES_W-1:0]   resB;
  wire [RES_W-1:0]   resS;
  wire [POS_W-1:0]   posAlB;
  wire [POS_W-1:0]   posAlS;
  wire               errBit;
  wire               ssiBit;
  wire [CRCIN_W-1:0] crcIn;
  wire [CRC_W-1:0]   crcVal;
  wire [7:0]         tail;
  wire [FRM_W-1:0]   frameB;
  wire [FRM_W-1:0]   frameS;
  wire [LEN_W-1:0]   lenB;
  wire [LEN_W-1:0]   lenS;
  wire [FRM_W-1:0]   frameSel;
  wire [LEN_W-1:0]   lenSel;
  wire [LEN_W-1:0]   tailShift;

  assign riseEdge = clkS2_ff & ~clkS3_ff;
  assign fallEdge = ~clkS2_ff & clkS3_ff;
  assign anyEdge  = riseEdge | fallEdge;

  // Sampled link clock is the two-flop-synchronised level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clkS1_ff <= IDLE_LVL;
      clkS2_ff <= IDLE_LVL;
      clkS3_ff <= IDLE_LVL;
    end else begin
      clkS1_ff <= linkClkIn;
      clkS2_ff <= clkS1_ff;
      clkS3_ff <= clkS2_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refCnt_ff    <= REF_RELOAD;
      sampleReq_ff <= 1'b0;
    end else begin
      sampleReq_ff <= (refCnt_ff == '0);
      refCnt_ff    <= (refCnt_ff == '0) ? REF_RELOAD : refCnt_ff - 1'b1;
    end
  end

  // Samples queue while a frame is being shifted
  pos_fifo #(
    .WIDTH (POS_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inValid  (posValid),
    .inData   (posData),
    .inReady  (posReady),
    .outValid (fifoValid),
    .outData  (fifoData),
    .outReady (fifoReady)
  );

  // Frame holds its sample; refresh only between frames
  assign fifoReady = (state_ff != ST_SHIFT);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sample_ff <= '0;
    end else if (fifoValid & fifoReady) begin
      sample_ff <= fifoData;
    end
  end

  assign resB   = clampRes(resBits, RES_MIN_BISS);
  assign resS   = clampRes(resBits, RES_MIN_SSI);
  assign posAlB = alignPos(sample_ff, resB);
  assign posAlS = alignPos(sample_ff, resS);

  assign errBit = bitFitted ? ~bitFault : 1'b1;
  assign ssiBit = bitFault;

  assign crcIn  = {posAlB, 2'h0} | ({errBit, WARN_VAL, 20'h0} >> resB);
  assign crcVal = crc6(crcIn, LEN_W'(resB) + 6'h02);

  // CRC inverted behind error and warning
  assign tail      = {errBit, WARN_VAL, ~crcVal};
  assign tailShift = HEAD_LEN + LEN_W'(resB);

  // Ack low, start high, zero bit
  assign frameB = {BISS_HEAD, posAlB, 9'h0} | ({tail, 24'h0} >> tailShift);
  assign lenB   = HEAD_LEN + LEN_W'(resB) + TAIL_LEN;

  // Position MSB first, test bit after
  assign frameS = {posAlS, 12'h0} | ({ssiBit, 31'h0} >> resS);
  // No extra bit when not fitted
  assign lenS   = LEN_W'(resS) + LEN_W'(bitFitted);

  assign frameSel = fmtBiss ? frameB : frameS;
  assign lenSel   = fmtBiss ? lenB : lenS;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff    <= ST_IDLE;
      shift_ff    <= '0;
      bitsLeft_ff <= '0;
      toCnt_ff    <= '0;
      dataOut_ff  <= IDLE_LVL;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          dataOut_ff <= IDLE_LVL;
          if (serviceReq) begin
            state_ff <= ST_SERVICE;
          end else if (fallEdge) begin
            shift_ff    <= frameSel;
            bitsLeft_ff <= lenSel;
            toCnt_ff    <= TIMEOUT_CYC;
            state_ff    <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (riseEdge && bitsLeft_ff != '0) begin
            dataOut_ff  <= shift_ff[FRM_W-1];
            shift_ff    <= shift_ff << 1;
            bitsLeft_ff <= bitsLeft_ff - 1'b1;
            toCnt_ff    <= TIMEOUT_CYC;
          end else if (riseEdge || toCnt_ff == '0) begin
            // Frame done or master broke off
            dataOut_ff <= MONO_LVL;
            toCnt_ff   <= TIMEOUT_CYC;
            state_ff   <= ST_TIMEOUT;
          end else if (fallEdge) begin
            toCnt_ff <= TIMEOUT_CYC;
          end else begin
            toCnt_ff <= toCnt_ff - 1'b1;
          end
        end
        ST_TIMEOUT: begin
          dataOut_ff <= MONO_LVL;
          if (anyEdge) begin
            toCnt_ff <= TIMEOUT_CYC;
          end else if (toCnt_ff == '0) begin
            dataOut_ff <= IDLE_LVL;
            state_ff   <= ST_IDLE;
          end else begin
            toCnt_ff <= toCnt_ff - 1'b1;
          end
        end
        ST_SERVICE: begin
          dataOut_ff <= serviceTx;
          if (!serviceReq) begin
            dataOut_ff <= MONO_LVL;
            toCnt_ff   <= TIMEOUT_CYC;
            state_ff   <= ST_TIMEOUT;
          end
        end
      endcase
    end
  end

  assign dataOut       = dataOut_ff;
  assign sampleReq     = sampleReq_ff;
  assign serviceRx     = clkS2_ff;
  assign serviceActive = (state_ff == ST_SERVICE);

endmodule
`default_nettype wire

// >>> design/enc_out_pkg.sv
/*
  Constants, types and helpers for the encoder position serial output.
  Assumes a 25 MHz system clock and a master that drives the link clock.
*/
// How it works
// - After reset the block serves position frames until serviceReq asks for the service mode.
// - Service mode turns the clock pair into receive and data pair into transmit.
// - Position sample is refreshed at 35 kHz, build option up to 375 kHz.
// - Point to point link, master clock 0.1 to 5 MHz, one bit per period.
// - Synchronous format test bit: 0 normal, 1 fault; absent when not fitted.
// - BiSS frame is one-way, timed by the master clock, continuous mode.
// - BiSS frame opens with a one-period acknowledge slot driven low.
// - Acknowledge is followed by start bit 1, then one zero bit.
// - Position field is 17 to 20 bits wide, from frame bit 8 upward.
// - Error bit at position 7 is active low, warning at 6 always 1.
// - Six-bit CRC, polynomial x^6+x+1, over position, error and warning.
// - CRC goes MSB first and inverted; start and zero bits are excluded.
// - A 25 us timeout after each BiSS frame before the next request.
`default_nettype none
package enc_out_pkg;

  // Clock
  localparam int CLK_MHZ = 25;
  localparam int CLK_HZ  = CLK_MHZ * 1000000;

  // Position refresh
  localparam int REFRESH_HZ_DEF = 35000;
  localparam int REFRESH_HZ_MAX = 375000;
  localparam int REF_W          = 16;

  // Frame timeout, least time so rounded up
  localparam int TIMEOUT_NS = 25000;
  localparam int TO_W       = 10;
  localparam logic [TO_W-1:0] TIMEOUT_CYC = TO_W'((TIMEOUT_NS * CLK_MHZ + 999) / 1000);

  // Field widths
  localparam int POS_W  = 20;
  localparam int RES_W  = 5;
  localparam int LEN_W  = 6;
  localparam int FRM_W  = 32;
  localparam int CRC_W  = 6;
  localparam int CRCIN_W = POS_W + 2;
  localparam int FIFO_DEPTH = 4;

  // Resolution limits per format
  localparam logic [RES_W-1:0] RES_MIN_BISS = 5'h11;
  localparam logic [RES_W-1:0] RES_MIN_SSI  = 5'h0c;
  localparam logic [RES_W-1:0] RES_MAX      = 5'h14;

  // BiSS frame pieces
  localparam logic [2:0]       BISS_HEAD = 3'h2;
  localparam logic [LEN_W-1:0] HEAD_LEN  = 6'h03;
  localparam logic [LEN_W-1:0] TAIL_LEN  = 6'h08;
  localparam logic             WARN_VAL  = 1'h1;
  localparam logic [CRC_W-1:0] CRC_POLY  = 6'h03;

  // Link levels
  localparam logic IDLE_LVL = 1'h1;
  localparam logic MONO_LVL = 1'h0;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_TIMEOUT, ST_SERVICE} state_t;

  // Clamp the resolution into the legal span of a format
  function automatic logic [RES_W-1:0] clampRes(input logic [RES_W-1:0] res,
                                                input logic [RES_W-1:0] lo);
    if (res < lo) begin
      return lo;
    end else if (res > RES_MAX) begin
      return RES_MAX;
    end
    return res;
  endfunction

  // Left-align the low res bits of a position word
  function automatic logic [POS_W-1:0] alignPos(input logic [POS_W-1:0] pos,
                                                input logic [RES_W-1:0] res);
    logic [RES_W-1:0] sh;
    sh = RES_MAX - res;
    return pos << sh;
  endfunction

endpackage
`default_nettype wire

// >>> design/pos_fifo.sv
/*
  Small flip-flop FIFO with valid and ready on both sides.
  Assumes both sides run on the same clock with a synchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module pos_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Drain side
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wrIdx_ff;
  logic [AW-1:0]    rdIdx_ff;
  logic [AW:0]      count_ff;
  wire              push;
  wire              pop;

  assign inReady  = (count_ff != (AW+1)'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData  = mem_ff[rdIdx_ff];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wrIdx_ff] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrIdx_ff <= '0;
      rdIdx_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wrIdx_ff <= (wrIdx_ff == AW'(DEPTH-1)) ? '0 : wrIdx_ff + 1'b1;
      end
      if (pop) begin
        rdIdx_ff <= (rdIdx_ff == AW'(DEPTH-1)) ? '0 : rdIdx_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// >>> testbench/enc_out_assertions.sv
/*
  Checker for the encoder serial output: link timing, service mode, refresh.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module enc_out_assertions
  import enc_out_pkg::*;
#(
  parameter int REFRESH_HZ = REFRESH_HZ_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link and service
  input wire logic linkClkIn,
  input wire logic dataOut,
  input wire logic serviceReq,
  input wire logic serviceTx,
  input wire logic serviceActive,
  // Position source
  input wire logic sampleReq,
  input wire logic posReady
);
  localparam int GAP   = CLK_HZ / REFRESH_HZ;
  localparam int TO_LO = 615;
  localparam int TO_HI = 640;

  logic [9:0]       quiet_ff;
  logic [9:0]       nxt_quiet;
  logic             prevLink_ff;
  logic [REF_W-1:0] gap_ff;
  logic [REF_W-1:0] nxt_gap;

  // Cycles since a link edge, zero in service mode
  assign nxt_quiet = (linkClkIn != prevLink_ff || serviceActive) ? 10'h000 :
                     (quiet_ff == 10'h3ff) ? quiet_ff : quiet_ff + 10'h001;
  assign nxt_gap   = sampleReq ? 16'h0001 : gap_ff + 16'h0001;

  always_ff @(posedge clk) begin
    prevLink_ff <= linkClkIn;
    quiet_ff    <= sys_rst ? 10'h000 : nxt_quiet;
    gap_ff      <= sys_rst ? 16'h0000 : nxt_gap;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence svcSteady;
    serviceActive && $past(serviceActive) && $past(serviceActive, 2);
  endsequence
  sequence lateRise;
    $rose(dataOut) && quiet_ff > 10'h00a;
  endsequence

  reset_idle_a: assert property (
    $fell(sys_rst) |-> dataOut && !serviceActive && posReady)
    else $error("outputs not idle after reset");
  svc_enter_a: assert property (
    $rose(serviceActive) |-> $past(serviceReq) && $past(dataOut))
    else $error("service entered outside idle");
  svc_echo_a: assert property (
    svcSteady |-> dataOut == $past(serviceTx))
    else $error("service transmit not echoed");
  svc_leave_a: assert property (
    $fell(serviceActive) |-> ##[0:2] !dataOut)
    else $error("no timeout after service");
  sample_pulse_a: assert property (
    sampleReq |=> (!sampleReq) [*8])
    else $error("refresh pulse too long");
  sample_gap_a: assert property (
    gap_ff != 16'h0000 |-> (sampleReq ? gap_ff == GAP : gap_ff < GAP))
    else $error("refresh interval wrong");
  idle_high_a: assert property (
    quiet_ff > 10'h2bc |-> dataOut)
    else $error("data not idle high");
  timeout_len_a: assert property (
    lateRise |-> quiet_ff >= TO_LO && quiet_ff <= TO_HI)
    else $error("timeout length wrong");
  bit_timing_a: assert property (
    $changed(dataOut) && !serviceActive && !$past(serviceActive)
      |-> quiet_ff <= 10'h008 || (quiet_ff >= TO_LO && quiet_ff <= TO_HI))
    else $error("data changed away from link edge");
endmodule
`default_nettype wire

// >>> testbench/link_master.sv
/*
  Master model: drives the link clock and reads the data line.
  Assumes one bench process calls its tasks.
*/
`timescale 1ns/10ps
`default_nettype none
module link_master (
  // Link pins
  output logic      linkClk,
  input  wire logic dataLine
);
  initial linkClk = 1'b1;

  task automatic frame(input int n, output logic [63:0] got);
    #27013;
    got = '0;
    linkClk = 1'b0;
    #160 linkClk = 1'b1;
    for (int i = 0; i < n; i++) begin
      #160 linkClk = 1'b0;
      #160 got = {got[62:0], dataLine};
      linkClk = 1'b1;
    end
  endtask

  task automatic level(input logic v);
    linkClk = v;
  endtask
endmodule
`default_nettype wire

// >>> testbench/encoder_position_serial_out_bench.sv
/*
  Self-checking bench for the encoder serial output.
  Assumes the master model and the checker are compiled with it.
*/
`timescale 1ns/10ps
`default_nettype none
module encoder_position_serial_out_bench
  import enc_out_pkg::*;
;
  localparam int REFR = REFRESH_HZ_MAX;

  logic             clk;
  logic             sys_rst;
  logic             linkClk;
  logic             dataOut;
  logic             fmtBiss;
  logic [RES_W-1:0] resBits;
  logic             bitFitted;
  logic             bitFault;
  logic             serviceReq;
  logic             serviceRx;
  logic             serviceTx;
  logic             serviceActive;
  logic             sampleReq;
  logic [POS_W-1:0] posData;
  logic             posValid;
  logic             posReady;
  int               err_total = 0;
  int               checks_done = 0;
  int               cyc = 0;

  encoder_position_serial_out #(.REFRESH_HZ(REFR)) DUT (
    .clk(clk), .sys_rst(sys_rst), .linkClkIn(linkClk), .dataOut(dataOut),
    .fmtBiss(fmtBiss), .resBits(resBits), .bitFitted(bitFitted),
    .bitFault(bitFault), .serviceReq(serviceReq), .serviceRx(serviceRx),
    .serviceTx(serviceTx), .serviceActive(serviceActive), .sampleReq(sampleReq),
    .posData(posData), .posValid(posValid), .posReady(posReady)
  );
  link_master LM (.linkClk(linkClk), .dataLine(dataOut));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_sim();
    $display("errors %0d, checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic check(input logic [63:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  function automatic logic [63:0] exp_frame(input logic biss, input int res,
                                            input logic fit, flt, input logic [19:0] p);
    logic [63:0] e;
    logic [5:0]  c;
    logic        b;
    e = biss ? 64'h2 : 64'h0;
    c = 6'h00;
    for (int i = res - 1; i >= 0; i--)
      e = {e[62:0], p[i]};
    if (biss) begin
      e = {e[61:0], ~(fit & flt), WARN_VAL};
      for (int i = res + 1; i >= 0; i--) begin
        b = c[5] ^ e[i];
        c = {c[4:0], 1'b0} ^ (b ? CRC_POLY : 6'h00);
      end
      e = {e[57:0], ~c};
    end else if (fit)
      e = {e[62:0], flt};
    return e;
  endfunction

  task automatic t_frame(input logic biss, input int res, input logic fit, flt,
                         input logic [19:0] p);
    logic [63:0] got;
    int          k;
    @(posedge clk);
    fmtBiss <= biss;
    resBits <= res[RES_W-1:0];
    bitFitted <= fit;
    bitFault <= flt;
    posData <= p;
    posValid <= 1'b1;
    LM.frame(biss ? res + 11 : res + fit, got);
    check(posReady, 1'b0, "buffer not full during frame");
    check(got, exp_frame(biss, res, fit, flt, p), "frame bits");
    repeat (20) @(negedge clk);
    check(dataOut, 1'b0, "timeout not low");
    check(posReady, 1'b1, "buffer not drained");
    k = 0;
    while (dataOut !== 1'b1 && k < 800) begin
      @(negedge clk);
      k++;
    end
    check(k >= 595 && k <= 615, 1'b1, "timeout length");
  endtask

  task automatic t_sample();
    int g;
    g = 0;
    while (sampleReq !== 1'b1 && g < 100) begin
      @(negedge clk);
      g++;
    end
    g = 0;
    do begin
      @(negedge clk);
      g++;
    end while (sampleReq !== 1'b1 && g < 100);
    check(g, CLK_HZ / REFR, "refresh interval");
  endtask

  task automatic t_service();
    @(posedge clk) serviceReq <= 1'b1;
    repeat (3) @(negedge clk);
    check(serviceActive, 1'b1, "service not entered");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) serviceTx <= i[0];
      repeat (3) @(negedge clk);
      check(dataOut, i[0], "service transmit");
    end
    LM.level(1'b0);
    repeat (6) @(negedge clk);
    check(serviceRx, 1'b0, "service receive low");
    LM.level(1'b1);
    repeat (6) @(negedge clk);
    check(serviceRx, 1'b1, "service receive high");
    @(posedge clk) serviceReq <= 1'b0;
    repeat (4) @(negedge clk);
    check({serviceActive, dataOut}, 2'b00, "service exit");
    repeat (700) @(negedge clk);
    check(dataOut, 1'b1, "idle after service");
  endtask

  task automatic t_reset();
    @(posedge clk) serviceReq <= 1'b1;
    repeat (3) @(negedge clk);
    @(posedge clk) serviceReq <= 1'b0;
    repeat (4) @(negedge clk);
    check(dataOut, 1'b0, "timeout before reset");
    @(posedge clk) sys_rst <= 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(negedge clk);
    check({dataOut, serviceActive, posReady, serviceRx}, 4'hb, "levels after reset");
  endtask

  initial begin
    sys_rst = 1'b1;
    fmtBiss = 1'b0;
    resBits = 5'h0c;
    bitFitted = 1'b0;
    bitFault = 1'b0;
    serviceReq = 1'b0;
    serviceTx = 1'b1;
    posData = 20'h00000;
    posValid = 1'b0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(negedge clk);
    check({dataOut, serviceActive, posReady, serviceRx}, 4'hb, "reset levels");
    t_sample();
    t_frame(1'b1, 17, 1'b1, 1'b0, 20'h5a3c6);
    t_frame(1'b1, 20, 1'b1, 1'b1, 20'hc0f31);
    t_frame(1'b1, 18, 1'b0, 1'b1, 20'h2d8e7);
    t_frame(1'b0, 12, 1'b1, 1'b1, 20'h00b4d);
    t_frame(1'b0, 20, 1'b0, 1'b0, 20'h9e21c);
    t_service();
    t_reset();
    t_frame(1'b0, 13, 1'b1, 1'b0, 20'h01a5f);
    end_sim();
  end
endmodule

bind encoder_position_serial_out enc_out_assertions #(.REFRESH_HZ(REFRESH_HZ)) chk (
  .clk(clk), .sys_rst(sys_rst), .linkClkIn(linkClkIn), .dataOut(dataOut),
  .serviceReq(serviceReq), .serviceTx(serviceTx), .serviceActive(serviceActive),
  .sampleReq(sampleReq), .posReady(posReady)
);
`default_nettype wire
